/* logic/lcd_panel_timing_config.v */
// panel size, data format, shade, extra line clock, frame start and shadow timing
`include "lcd_panel_timing_regs.vh"

module lcd_panel_timing_config
(
   input wire clk,
   input wire reset,
   input wire ce,
   input wire [7:0] io_index,
   input wire [7:0] io_wdata,
   input wire io_wr,
   input wire io_rd,
   output reg [7:0] io_rdata,
   output reg io_rd_ack,
   input wire panel_ext_unlock_ctrl,
   input wire [1:0] shadow_bank_select,
   input wire seq_clocking_mode,
   input wire [1:0] misc_line_count,
   input wire vert_expand_en,
   input wire auto_center_en,
   input wire panel_525_line,
   input wire [9:0] other_lfs_pos,
   input wire [7:0] crt_horiz_total,
   input wire [7:0] crt_horiz_blank_start,
   output reg [7:0] horiz_total_out,
   output reg [7:0] horiz_blank_start_out,
   input wire crt_frame_start,
   input wire line_strobe,
   output reg line_frame_start,
   input wire [23:0] pixel_in,
   output reg [23:0] pixel_out,
   input wire [3:0] shade_in,
   output reg [3:0] shade_out,
   input wire row_clock_in,
   input wire half_boundary,
   output reg panel_row_clock,
   output reg [1:0] panel_size_code,
   output reg panel_size_valid
);

   // ==================================================
   // register storage
   reg [3:0] size_fmt_r;
   reg [4:0] extra_shade_r;
   reg [7:0] pos525_low_r;
   reg [7:0] possix_low_r;
   reg [3:0] pos_ovf_r;
   reg [7:0] shadow_htotal_r;
   reg [7:0] shadow_hbstart_r;
   reg [9:0] line_cnt_r;
   reg [2:0] extra_left_r;
   reg [3:0] gap_cnt_r;

   wire ext_open;
   wire bank_open;
   wire wr_ok;
   wire rd_ok;
   wire [1:0] size_code;
   wire [1:0] fmt_code;
   wire [2:0] extra_req;
   wire [9:0] pos525;
   wire [9:0] possix;
   wire use525;
   wire usesix;
   wire [9:0] lfs_pos;
   wire shadow_drive;
   wire row_slot_free;
   reg [7:0] rd_nxt;
   reg [3:0] shade_nxt;

   // extension registers sit behind the unlock bit
   function is_ext;
      input [7:0] idx;
      begin
         is_ext = (idx >= `IDX_EXT_FIRST) && (idx <= `IDX_EXT_LAST);
      end
   endfunction

   // the shadow bank answers on two indexes of its own
   function is_bank;
      input [7:0] idx;
      begin
         is_bank = (idx == `IDX_SHADOW_HTOTAL) || (idx == `IDX_SHADOW_HBSTART);
      end
   endfunction

   // keep the top bits of one colour, zero the rest
   function [7:0] cut_colour;
      input [7:0] c;
      input [1:0] fmt;
      begin
         case (fmt)
            `FMT_9: cut_colour = {c[7:5], 5'h00};
            `FMT_12: cut_colour = {c[7:4], 4'h0};
            `FMT_18: cut_colour = {c[7:2], 2'h0};
            default: cut_colour = c;
         endcase
      end
   endfunction

   assign ext_open = is_ext(io_index) && panel_ext_unlock_ctrl;
   assign bank_open = is_bank(io_index) && (shadow_bank_select == `BANK_A);
   assign wr_ok = io_wr && (ext_open || bank_open);
   assign rd_ok = ext_open || bank_open;

   assign size_code = size_fmt_r[`SIZE_MSB:`SIZE_LSB];
   assign fmt_code = size_fmt_r[`FMT_MSB:`FMT_LSB];
   // codes 6 and 7 are not defined; they are held to the five-clock maximum
   assign extra_req = (extra_shade_r[`EXTRA_MSB:`EXTRA_LSB] > `EXTRA_MAX) ?
      `EXTRA_MAX : extra_shade_r[`EXTRA_MSB:`EXTRA_LSB];

   assign pos525 = {pos_ovf_r[`OVF_525_MSB:`OVF_525_LSB], pos525_low_r};
   assign possix = {pos_ovf_r[`OVF_SIX_MSB:`OVF_SIX_LSB], possix_low_r};
   assign use525 = (misc_line_count == `LINES_350) && vert_expand_en &&
      panel_525_line;
   assign usesix = (size_code == `SIZE_800) && (misc_line_count == `LINES_SIX) &&
      !vert_expand_en && auto_center_en;
   // the 525 position wins over the sixth, the sixth over the outside value
   assign lfs_pos = use525 ? pos525 : (usesix ? possix : other_lfs_pos);

   // reserved panel sizes leave crt timing untouched
   assign shadow_drive = !seq_clocking_mode &&
      ((size_code == `SIZE_640) || (size_code == `SIZE_800));

   // an extra row clock needs an idle input and an idle output, or it
   // would merge with a real row clock into one long pulse that the panel counts once
   assign row_slot_free = !row_clock_in && !panel_row_clock;

   // ==================================================
   // read mux
   always @*
   begin
      // locked, unselected and reserved bits all read back as zero
      rd_nxt = 8'h00;
      if (rd_ok)
      begin
         case (io_index)
            `IDX_PANEL_SIZE_FMT: rd_nxt = {4'h0, size_fmt_r};
            `IDX_EXTRA_SHADE: rd_nxt = {3'h0, extra_shade_r};
            `IDX_POS525_LOW: rd_nxt = pos525_low_r;
            `IDX_POSSIX_LOW: rd_nxt = possix_low_r;
            `IDX_POS_OVERFLOW: rd_nxt = {4'h0, pos_ovf_r};
            `IDX_SHADOW_HTOTAL: rd_nxt = shadow_htotal_r;
            `IDX_SHADOW_HBSTART: rd_nxt = shadow_hbstart_r;
            default: rd_nxt = 8'h00;
         endcase
      end
   end

   // ==================================================
   // shade conversion
   always @*
   begin
      // all four tests look at the input, so one conversion never feeds another
      shade_nxt = shade_in;
      if (extra_shade_r[`SHADE79_BIT] && (shade_in == 4'h7))
         shade_nxt = 4'h6;
      if (extra_shade_r[`SHADE79_BIT] && (shade_in == 4'h9))
         shade_nxt = 4'h8;
      if (extra_shade_r[`SHADE511_BIT] && (shade_in == 4'h5))
         shade_nxt = 4'h4;
      if (extra_shade_r[`SHADE511_BIT] && (shade_in == 4'hB))
         shade_nxt = 4'hA;
   end

   // ==================================================
   // register writes and reads
   always @(posedge clk)
   begin
      if (reset)
      begin
         size_fmt_r <= `RST_PANEL_SIZE_FMT;
         extra_shade_r <= `RST_EXTRA_SHADE;
         pos525_low_r <= `RST_POS_LOW;
         possix_low_r <= `RST_POS_LOW;
         pos_ovf_r <= `RST_POS_OVERFLOW;
         shadow_htotal_r <= `RST_SHADOW;
         shadow_hbstart_r <= `RST_SHADOW;
         io_rdata <= 8'h00;
         io_rd_ack <= 1'b0;
      end
      else if (ce)
      begin
         io_rd_ack <= io_rd;
         if (io_rd)
            io_rdata <= rd_nxt;
         // a write to a locked or unselected index is dropped without trace
         if (wr_ok)
         begin
            case (io_index)
               `IDX_PANEL_SIZE_FMT: size_fmt_r <= io_wdata[3:0];
               `IDX_EXTRA_SHADE: extra_shade_r <= io_wdata[4:0];
               `IDX_POS525_LOW: pos525_low_r <= io_wdata;
               `IDX_POSSIX_LOW: possix_low_r <= io_wdata;
               `IDX_POS_OVERFLOW: pos_ovf_r <= io_wdata[3:0];
               `IDX_SHADOW_HTOTAL: shadow_htotal_r <= io_wdata;
               `IDX_SHADOW_HBSTART: shadow_hbstart_r <= io_wdata;
               default: pos_ovf_r <= pos_ovf_r;
            endcase
         end
      end
   end

   // ==================================================
   // scanline count and frame start
   always @(posedge clk)
   begin
      if (reset)
      begin
         line_cnt_r <= 10'h000;
         line_frame_start <= 1'b0;
      end
      else if (ce)
      begin
         // the count wraps after 1023, beyond any ten-bit position
         if (crt_frame_start)
            line_cnt_r <= 10'h000;
         else if (line_strobe)
            line_cnt_r <= line_cnt_r + 10'h001;
         // one pulse per frame, on the line whose count matches
         line_frame_start <= line_strobe && !crt_frame_start &&
            (line_cnt_r == lfs_pos);
      end
   end

   // ==================================================
   // row clock with extra clocks between the panel halves
   always @(posedge clk)
   begin
      if (reset)
      begin
         extra_left_r <= 3'h0;
         gap_cnt_r <= 4'h0;
         panel_row_clock <= 1'b0;
      end
      else if (ce)
      begin
         panel_row_clock <= row_clock_in;
         if (half_boundary)
         begin
            extra_left_r <= extra_req;
            gap_cnt_r <= `EXTRA_GAP;
         end
         else if (extra_left_r != 3'h0)
         begin
            // a real row clock takes the slot; the extra one waits until it is over
            // limitation: a real clock arriving just after an extra one still joins it
            if (gap_cnt_r != 4'h0)
               gap_cnt_r <= gap_cnt_r - 4'h1;
            else if (row_slot_free)
            begin
               panel_row_clock <= 1'b1;
               extra_left_r <= extra_left_r - 3'h1;
               gap_cnt_r <= `EXTRA_GAP;
            end
         end
      end
   end

   // ==================================================
   // pixel, shade and timing outputs
   always @(posedge clk)
   begin
      if (reset)
      begin
         pixel_out <= 24'h00_0000;
         shade_out <= 4'h0;
         horiz_total_out <= 8'h00;
         horiz_blank_start_out <= 8'h00;
         // the 640x480 code is a valid size, so valid comes out of reset high
         panel_size_code <= `SIZE_640;
         panel_size_valid <= 1'b1;
      end
      else if (ce)
      begin
         pixel_out <= {cut_colour(pixel_in[23:16], fmt_code),
            cut_colour(pixel_in[15:8], fmt_code),
            cut_colour(pixel_in[7:0], fmt_code)};
         shade_out <= shade_nxt;
         horiz_total_out <= shadow_drive ? shadow_htotal_r : crt_horiz_total;
         horiz_blank_start_out <= shadow_drive ? shadow_hbstart_r :
            crt_horiz_blank_start;
         panel_size_code <= size_code;
         panel_size_valid <= (size_code == `SIZE_640) || (size_code == `SIZE_800);
      end
   end

endmodule

/* logic/lcd_panel_timing_regs.vh */
// register indexes, field positions and reset values of the panel timing block
`ifndef LCD_PANEL_TIMING_REGS_VH
`define LCD_PANEL_TIMING_REGS_VH
// ==================================================
// indexes on the indexed port
`define IDX_SHADOW_HTOTAL 8'h00
`define IDX_SHADOW_HBSTART 8'h02
`define IDX_PANEL_SIZE_FMT 8'h09
`define IDX_EXTRA_SHADE 8'h0B
`define IDX_POS525_LOW 8'h0C
`define IDX_POSSIX_LOW 8'h0D
`define IDX_POS_OVERFLOW 8'h0E
`define IDX_EXT_FIRST 8'h09
`define IDX_EXT_LAST 8'h0E
// ==================================================
// field positions
`define SIZE_MSB 3
`define SIZE_LSB 2
`define FMT_MSB 1
`define FMT_LSB 0
`define SHADE79_BIT 4
`define SHADE511_BIT 3
`define EXTRA_MSB 2
`define EXTRA_LSB 0
`define OVF_SIX_MSB 3
`define OVF_SIX_LSB 2
`define OVF_525_MSB 1
`define OVF_525_LSB 0
// ==================================================
// codes
`define SIZE_640 2'h0
`define SIZE_800 2'h1
`define FMT_9 2'h0
`define FMT_12 2'h1
`define FMT_18 2'h2
`define FMT_24 2'h3
`define LINES_350 2'h2
`define LINES_SIX 2'h3
`define BANK_A 2'h2
`define EXTRA_MAX 3'h5
`define EXTRA_GAP 4'h2
// ==================================================
// reset values
`define RST_PANEL_SIZE_FMT 4'h0
`define RST_EXTRA_SHADE 5'h00
`define RST_POS_LOW 8'h00
`define RST_POS_OVERFLOW 4'h0
`define RST_SHADOW 8'h00
`endif

/* test/lcd_panel_model.sv */
// panel side model: counts the row clocks and frame starts it receives
module lcd_panel_model
(
   input wire clk,
   input wire panel_row_clock,
   input wire line_frame_start,
   output int rows,
   output int frames
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // a row per rising edge of the row clock, as a panel shifts on edges; a frame per frame start
   logic row_prev = 1'b0;
   initial rows = 0;
   initial frames = 0;
   always @(posedge clk)
   begin
      row_prev <= panel_row_clock;
      rows <= rows + int'(panel_row_clock && !row_prev);
      frames <= frames + int'(line_frame_start);
   end
endmodule

/* test/lcd_panel_timing_config_monitor.sv */
// checker of the panel timing block port relations
module lcd_panel_timing_config_monitor
(
   input wire clk,
   input wire reset,
   input wire ce,
   input wire [7:0] io_index,
   input wire io_rd,
   input wire [7:0] io_rdata,
   input wire io_rd_ack,
   input wire panel_ext_unlock_ctrl,
   input wire [1:0] shadow_bank_select,
   input wire seq_clocking_mode,
   input wire [7:0] crt_horiz_total,
   input wire [7:0] horiz_total_out,
   input wire line_strobe,
   input wire line_frame_start,
   input wire [23:0] pixel_in,
   input wire [23:0] pixel_out,
   input wire [3:0] shade_in,
   input wire [3:0] shade_out,
   input wire row_clock_in,
   input wire panel_row_clock,
   input wire [1:0] panel_size_code,
   input wire panel_size_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // port relations
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   a_read_ack: assert property (ce && io_rd |=> io_rd_ack) else $error("ack missing");
   a_ack_single: assert property (ce && !io_rd |=> !io_rd_ack) else $error("stray ack");
   a_locked_zero: assert property (ce && io_rd && !panel_ext_unlock_ctrl &&
      io_index >= 8'h09 && io_index <= 8'h0e |=> io_rdata == 8'h00) else $error("locked read");
   a_bank_zero: assert property (ce && io_rd && shadow_bank_select != 2'h2 &&
      (io_index == 8'h00 || io_index == 8'h02) |=> io_rdata == 8'h00) else $error("bank read");
   a_size_valid: assert property (panel_size_valid |-> !panel_size_code[1]) else $error("size");
   a_pixel_trunc: assert property (ce |=> (pixel_out & ~$past(pixel_in)) == 24'h0)
      else $error("pixel bits added");
   a_shade_pass: assert property (ce && shade_in != 4'h7 && shade_in != 4'h9 &&
      shade_in != 4'h5 && shade_in != 4'hb |=> shade_out == $past(shade_in)) else $error("shade");
   a_crt_horiz: assert property (ce && seq_clocking_mode |=>
      horiz_total_out == $past(crt_horiz_total)) else $error("horiz total");
   a_row_copy: assert property (ce && row_clock_in |=> panel_row_clock) else $error("row");
   a_frame_strobe: assert property (line_frame_start |-> $past(line_strobe)) else $error("lfs");
endmodule
bind lcd_panel_timing_config lcd_panel_timing_config_monitor mon (.*);

/* test/lcd_panel_timing_config_test.sv */
// self-checking bench for the panel timing block
module lcd_panel_timing_config_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, reset = 1, ce = 1, io_wr = 0, io_rd = 0, panel_ext_unlock_ctrl = 1;
   logic seq_clocking_mode = 0, vert_expand_en = 0, auto_center_en = 0, panel_525_line = 0;
   logic crt_frame_start = 0, line_strobe = 0, row_clock_in = 0, half_boundary = 0;
   logic [1:0] shadow_bank_select = 2'h2, misc_line_count = 2'h0;
   logic [7:0] io_index = 8'h00, io_wdata = 8'h00, crt_horiz_total = 8'ha5;
   logic [7:0] crt_horiz_blank_start = 8'h5a;
   logic [9:0] other_lfs_pos = 10'h007;
   logic [23:0] pixel_in = 24'hff_ffff;
   logic [3:0] shade_in = 4'h0;
   wire [7:0] io_rdata, horiz_total_out, horiz_blank_start_out;
   wire io_rd_ack, line_frame_start, panel_row_clock, panel_size_valid;
   wire [23:0] pixel_out;
   wire [3:0] shade_out;
   wire [1:0] panel_size_code;
   int rows, frames, num_errors = 0, total_checks = 0, cycles = 0, r0, k, j;
   logic [7:0] ix[7] = '{8'h09, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h00, 8'h02};
   logic [7:0] wv[7] = '{8'hff, 8'hff, 8'h55, 8'haa, 8'hff, 8'h12, 8'h34};
   logic [7:0] ev[7] = '{8'h0f, 8'h1f, 8'h55, 8'haa, 8'h0f, 8'h12, 8'h34};
   logic [23:0] fm[4] = '{24'he0_e0e0, 24'hf0_f0f0, 24'hfc_fcfc, 24'hff_ffff};
   logic [15:0] sh[7] = '{16'h1076, 16'h1098, 16'h1055, 16'h0854, 16'h08ba, 16'h0877, 16'h0099};
   lcd_panel_timing_config DUT (.*);
   lcd_panel_model panel (.*);
   // ==========
   // clock, timeout and shared tasks
   initial forever #25 clk = ~clk;
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         num_errors++;
         give_verdict;
      end
   end
   task give_verdict;
      if (num_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [23:0] e, g);
      total_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] i, d);
      @(posedge clk);
      io_index <= i;
      io_wdata <= d;
      io_wr <= 1;
      @(posedge clk);
      io_wr <= 0;
   endtask
   task automatic rd(input logic [7:0] i, e);
      @(posedge clk);
      io_index <= i;
      io_rd <= 1;
      @(posedge clk);
      io_rd <= 0;
      #1;
      chk("io_rd_ack", 24'h1, {23'h0, io_rd_ack});
      chk("io_rdata", {16'h0, e}, {16'h0, io_rdata});
   endtask
   // a row clock lands on the first extra pulse, so one must be postponed
   task automatic extra(input logic [2:0] n, input int e);
      wr(8'h0b, {5'h00, n});
      r0 = rows;
      @(posedge clk);
      half_boundary <= 1;
      @(posedge clk);
      half_boundary <= 0;
      repeat (2) @(posedge clk);
      row_clock_in <= 1;
      @(posedge clk);
      row_clock_in <= 0;
      tick(30);
      chk("row clocks", 24'(e + 1), 24'(rows - r0));
   endtask
   task automatic frame(input int p);
      @(posedge clk);
      crt_frame_start <= 1;
      @(posedge clk);
      crt_frame_start <= 0;
      for (k = 0; k <= p + 2; k++)
      begin
         @(posedge clk);
         line_strobe <= 1;
         @(posedge clk);
         line_strobe <= 0;
         #1;
         chk("line_frame_start", {23'h0, k == p}, {23'h0, line_frame_start});
      end
   endtask
   // ==========
   // main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      reset <= 0;
      for (j = 0; j < 7; j++) rd(ix[j], 8'h00);
      for (j = 0; j < 7; j++) wr(ix[j], wv[j]);
      for (j = 0; j < 7; j++) rd(ix[j], ev[j]);
      panel_ext_unlock_ctrl <= 0;
      wr(8'h0c, 8'h11);
      rd(8'h0c, 8'h00);
      rd(8'h09, 8'h00);
      panel_ext_unlock_ctrl <= 1;
      rd(8'h0c, 8'h55);
      shadow_bank_select <= 2'h1;
      wr(8'h00, 8'h99);
      rd(8'h00, 8'h00);
      shadow_bank_select <= 2'h2;
      rd(8'h00, 8'h12);
      rd(8'h05, 8'h00);
      rd(8'h0f, 8'h00);
      wr(8'h09, 8'h04);
      tick(2);
      chk("horiz_total_out", 24'h12, {16'h0, horiz_total_out});
      chk("horiz_blank_start_out", 24'h34, {16'h0, horiz_blank_start_out});
      chk("panel_size_code", 24'h1, {22'h0, panel_size_code});
      seq_clocking_mode <= 1;
      tick(2);
      chk("horiz_total_out", 24'ha5, {16'h0, horiz_total_out});
      seq_clocking_mode <= 0;
      wr(8'h09, 8'h08);
      tick(2);
      chk("horiz_blank_start_out", 24'h5a, {16'h0, horiz_blank_start_out});
      chk("panel_size_valid", 24'h0, {23'h0, panel_size_valid});
      for (j = 0; j < 4; j++)
      begin
         wr(8'h09, {6'h00, j[1:0]});
         tick(2);
         chk("pixel_out", fm[j], pixel_out);
         chk("panel_size_valid", 24'h1, {23'h0, panel_size_valid});
      end
      chk("horiz_total_out", 24'h12, {16'h0, horiz_total_out});
      for (j = 0; j < 7; j++)
      begin
         wr(8'h0b, sh[j][15:8]);
         shade_in <= sh[j][7:4];
         tick(2);
         chk("shade_out", {20'h0, sh[j][3:0]}, {20'h0, shade_out});
      end
      for (j = 0; j < 8; j++) extra(j[2:0], (j > 5) ? 5 : j);
      misc_line_count <= 2'h2;
      vert_expand_en <= 1;
      panel_525_line <= 1;
      auto_center_en <= 1;
      wr(8'h09, 8'h04);
      wr(8'h0c, 8'h02);
      wr(8'h0e, 8'h09);
      wr(8'h0d, 8'h05);
      frame(258);
      misc_line_count <= 2'h3;
      vert_expand_en <= 0;
      frame(517);
      auto_center_en <= 0;
      r0 = frames;
      frame(7);
      chk("frames", 24'(r0 + 1), 24'(frames));
      ce <= 0;
      pixel_in <= 24'h00_0000;
      wr(8'h0c, 8'h77);
      tick(1);
      chk("pixel_out", 24'he0_e0e0, pixel_out);
      ce <= 1;
      rd(8'h0c, 8'h02);
      give_verdict;
   end
endmodule
